// [design/tcf_feature_ctrl.sv]
// How it works
// - fixed 32-bit model identifier, read only
// - user label word, writable and readable
// - read-only area or line scan kind
// - report sensor, limit and actual dimensions
// - hold column and row area shifts
// - software switches test pattern generator
// - hold capture count mode setting
// - begin and end actions start/stop capture
// - single trigger sends calibrate command, argument zero
// - nonzero period recalibrates every period*256 frames
// - calibration behaviour relayed with own letter
// - correction set number relayed for activation
// - refresh reloads features from internal settings
// - thermal flag, query sends temperature argument one
// - shutter celsius, query sends temperature argument two
// - shutter force state relayed as command
// - dual reference mode and targets file
// - low and high reference targets
// - first low and high reference files
// - backdrop mode read shows integration busy MSB
// - hold backdrop correction shift value
// - remap table mode and file number
`timescale 1ns/1ps
`default_nettype none
`include "tcf_regs.svh"

module tcf_feature_ctrl #(
    parameter logic [31:0] MODEL_ID = 32'h0000_0001, // arbitrary value
    parameter logic [31:0] SCAN_KIND = 32'h0000_0000,
    parameter logic [15:0] SENSOR_COLS = 16'h0280,
    parameter logic [15:0] SENSOR_ROWS = 16'h01E0,
    parameter logic [15:0] LIMIT_COLS = 16'h0280,
    parameter logic [15:0] LIMIT_ROWS = 16'h01E0,
    parameter logic [31:0] SAMPLE_LAYOUT = 32'h0000_0001,
    parameter int FW = 16
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic cmd_valid,
    output logic [7:0] cmd_letter,
    output logic [FW-1:0] cmd_arg,
    input wire logic cmd_ready,
    input wire logic resp_valid,
    input wire logic [FW-1:0] resp_value,
    input wire logic sync_valid,
    input wire logic [7:0] sync_letter,
    input wire logic [FW-1:0] sync_value,
    input wire logic sync_done,
    output logic feature_refresh_request,
    input wire logic calib_done,
    output logic calib_busy,
    input wire logic frame_tick,
    input wire logic integ_busy,
    input wire logic [15:0] out_columns,
    input wire logic [15:0] out_rows,
    output logic [15:0] roi_column_shift,
    output logic [15:0] roi_row_shift,
    output logic pattern_source_select,
    output logic [1:0] capture_count_mode,
    output logic capture_active,
    output logic thermal_condition_flag,
    output logic [FW-1:0] shutter_celsius
);
    import tcf_pkg::*;

    localparam int NF = `TCF_FEAT_COUNT;
    localparam logic [8*NF-1:0] LETTERS = `TCF_LETTERS;

    function automatic logic [7:0] feat_letter(input int idx);
        feat_letter = LETTERS[8*(NF-1-idx) +: 8];
    endfunction

    // feature slots sit four bytes apart, low address bits ignored except past the last slot at 0x74
    function automatic logic is_feat(input logic [7:0] a);
        is_feat = (a >= `TCF_OFS_FEAT_BASE) && (a <= `TCF_OFS_FEAT_LAST);
    endfunction

    function automatic int feat_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - `TCF_OFS_FEAT_BASE;
        feat_idx = int'(d[7:2]);
    endfunction

    // true on the tick that completes one interval
    function automatic logic period_hit(input logic [FW+7:0] cnt, input logic [FW+7:0] lim);
        period_hit = (cnt + 1'b1) >= lim;
    endfunction

    logic [31:0] user_label_r;
    logic [FW-1:0] feat_r [NF];
    logic [31:0] rdata_nxt;
    logic err_nxt;
    logic access;
    logic commit;
    logic wr_commit;
    logic needs_slot;
    logic bus_cmd;
    logic [7:0] bus_letter;
    logic [FW-1:0] bus_arg;
    logic calib_once_wr;
    logic launch_recal;
    logic recal_pend_r;
    logic [FW+7:0] frames_r;
    logic [FW+7:0] frame_limit;
    logic [FW+7:0] frames_nxt;
    tcf_refresh_state_t rf_state_r;
    tcf_query_kind_t q_kind_r;

    assign access = psel && penable;
    assign commit = access && pready;
    assign wr_commit = commit && pwrite;

    // command-issuing writes
    always_comb begin
        bus_cmd = 1'b0;
        bus_letter = 8'h00;
        bus_arg = '0;
        calib_once_wr = 1'b0;
        if (is_feat(paddr)) begin
            bus_cmd = 1'b1;
            bus_letter = feat_letter(feat_idx(paddr));
            bus_arg = pwdata[FW-1:0];
        end else if (paddr == `TCF_OFS_CALIB_CTRL && pwdata[0]) begin
            bus_cmd = 1'b1;
            calib_once_wr = 1'b1;
            bus_letter = `TCF_CMD_CALIB;
            bus_arg = `TCF_ARG_CALIB_ONCE;
        // thermal query: bit0 takes precedence over bit1
        end else if (paddr == `TCF_OFS_THERMAL && (pwdata[0] || pwdata[1])) begin
            bus_cmd = 1'b1;
            bus_letter = `TCF_CMD_TEMP;
            bus_arg = pwdata[0] ? `TCF_ARG_QUERY_THERMAL : `TCF_ARG_QUERY_SHUTTER;
        end
    end

    assign needs_slot = pwrite && bus_cmd;

    // read mux and address decode
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (is_feat(paddr)) begin
            rdata_nxt[FW-1:0] = feat_r[feat_idx(paddr)];
            if (feat_idx(paddr) == `TCF_FI_BACKDROP_MODE) begin
                rdata_nxt[`TCF_BIT_BUSY_MSB] = integ_busy;
            end
        end else begin
            unique case (paddr)
                `TCF_OFS_MODEL_ID: rdata_nxt = MODEL_ID;
                `TCF_OFS_USER_LABEL: rdata_nxt = user_label_r;
                `TCF_OFS_SCAN_KIND: rdata_nxt = SCAN_KIND;
                `TCF_OFS_SENSOR_DIMS: rdata_nxt = {SENSOR_ROWS, SENSOR_COLS};
                `TCF_OFS_OUT_LIMIT: rdata_nxt = {LIMIT_ROWS, LIMIT_COLS};
                `TCF_OFS_OUT_DIMS: rdata_nxt = {out_rows, out_columns};
                `TCF_OFS_ROI_SHIFT: rdata_nxt = {roi_row_shift, roi_column_shift};
                `TCF_OFS_SKIP_UNUSED: rdata_nxt = `TCF_SKIP_FIXED;
                `TCF_OFS_SAMPLE_LAYOUT: rdata_nxt = SAMPLE_LAYOUT;
                `TCF_OFS_PATTERN: rdata_nxt[0] = pattern_source_select;
                `TCF_OFS_CAPTURE_MODE: rdata_nxt[1:0] = capture_count_mode;
                `TCF_OFS_CAPTURE_CTRL: rdata_nxt[0] = capture_active;
                `TCF_OFS_CALIB_CTRL: rdata_nxt[0] = calib_busy;
                `TCF_OFS_REFRESH: rdata_nxt[0] = feature_refresh_request;
                `TCF_OFS_THERMAL: rdata_nxt[0] = thermal_condition_flag;
                `TCF_OFS_SHUTTER_C: rdata_nxt[FW-1:0] = shutter_celsius;
                // unmapped offsets read zero and answer with pslverr
                default: err_nxt = 1'b1;
            endcase
        end
    end

    // apb answer: ready one cycle after the access phase begins, held off
    // while a command write finds the command slot still occupied
    // prdata and pslverr then stand until the next access
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access && !pready && !(needs_slot && cmd_valid);
            if (access && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
                pslverr <= err_nxt;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            user_label_r <= `TCF_USER_LABEL_RST;
        end else if (wr_commit && paddr == `TCF_OFS_USER_LABEL) begin
            user_label_r <= pwdata;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            roi_column_shift <= 16'h0000;
            roi_row_shift <= 16'h0000;
            pattern_source_select <= 1'b0;
            capture_count_mode <= 2'h0;
        end else if (wr_commit) begin
            // no clamping: the host keeps shift plus size in range
            if (paddr == `TCF_OFS_ROI_SHIFT) begin
                roi_column_shift <= pwdata[15:0];
                roi_row_shift <= pwdata[31:16];
            end
            if (paddr == `TCF_OFS_PATTERN) begin
                pattern_source_select <= pwdata[0];
            end
            if (paddr == `TCF_OFS_CAPTURE_MODE) begin
                capture_count_mode <= pwdata[1:0];
            end
        end
    end

    // capture run state: single-frame mode stops itself after one frame
    // begin wins over end when both bits are written together
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            capture_active <= 1'b0;
        end else if (wr_commit && paddr == `TCF_OFS_CAPTURE_CTRL
                     && pwdata[`TCF_BIT_BEGIN]) begin
            capture_active <= 1'b1;
        end else if (wr_commit && paddr == `TCF_OFS_CAPTURE_CTRL
                     && pwdata[`TCF_BIT_END]) begin
            capture_active <= 1'b0;
        end else if (capture_active && frame_tick
                     && capture_count_mode == `TCF_MODE_SINGLE) begin
            capture_active <= 1'b0;
        end
    end

    // feature mirror: bus writes and refresh reports both land here
    // a bus write beats a refresh report to the same slot in one cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NF; i++) begin
                feat_r[i] <= `TCF_FEAT_RST;
            end
        end else begin
            for (int i = 0; i < NF; i++) begin
                if (wr_commit && is_feat(paddr) && feat_idx(paddr) == i) begin
                    feat_r[i] <= pwdata[FW-1:0];
                end else if (rf_state_r == TCF_RF_WAIT && sync_valid
                             && sync_letter == feat_letter(i)) begin
                    feat_r[i] <= sync_value;
                end
            end
        end
    end

    // single command slot toward the internal interpreter
    // a recal waits while a command write is in its access phase: pready may
    // already be granted, and the slot must then stay free for the bus write
    assign launch_recal = recal_pend_r && !cmd_valid && !(access && needs_slot);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_valid <= 1'b0;
            cmd_letter <= 8'h00;
            cmd_arg <= '0;
        end else if (wr_commit && bus_cmd) begin
            cmd_valid <= 1'b1;
            cmd_letter <= bus_letter;
            cmd_arg <= bus_arg;
        end else if (launch_recal) begin
            cmd_valid <= 1'b1;
            cmd_letter <= `TCF_CMD_CALIB;
            cmd_arg <= `TCF_ARG_CALIB_ONCE;
        end else if (cmd_valid && cmd_ready) begin
            cmd_valid <= 1'b0;
        end
    end

    // calibration in progress; a new start wins over a same-cycle done
    // a done with nothing running is harmless
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            calib_busy <= 1'b0;
        end else if ((wr_commit && calib_once_wr) || launch_recal) begin
            calib_busy <= 1'b1;
        end else if (calib_done) begin
            calib_busy <= 1'b0;
        end
    end

    // periodic recalibration frame counter; the interval counts units of 256 frames
    assign frame_limit = (FW+8)'(feat_r[`TCF_FI_CALIB_PERIOD]) << `TCF_FRAMES_PER_UNIT_LOG2;
    assign frames_nxt = frames_r + 1'b1;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            frames_r <= '0;
        end else if (feat_r[`TCF_FI_CALIB_PERIOD] == '0) begin
            frames_r <= '0;
        end else if (frame_tick) begin
            frames_r <= period_hit(frames_r, frame_limit) ? '0 : frames_nxt;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            recal_pend_r <= 1'b0;
        end else if (feat_r[`TCF_FI_CALIB_PERIOD] != '0 && frame_tick
                     && period_hit(frames_r, frame_limit)) begin
            recal_pend_r <= 1'b1;
        end else if (launch_recal) begin
            recal_pend_r <= 1'b0;
        end
    end

    // refresh sequence: report stream ends with sync_done
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rf_state_r <= TCF_RF_IDLE;
        end else begin
            unique case (rf_state_r)
                TCF_RF_IDLE: begin
                    // only an idle sequence takes a refresh start
                    if (wr_commit && paddr == `TCF_OFS_REFRESH && pwdata[0]) begin
                        rf_state_r <= TCF_RF_WAIT;
                    end
                end
                TCF_RF_WAIT: begin
                    if (sync_done) begin
                        rf_state_r <= TCF_RF_IDLE;
                    end
                end
            endcase
        end
    end

    assign feature_refresh_request = rf_state_r[1];

    // query answers are routed by the kind of the last query sent
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q_kind_r <= TCF_Q_THERMAL;
        end else if (wr_commit && paddr == `TCF_OFS_THERMAL && bus_cmd) begin
            q_kind_r <= pwdata[0] ? TCF_Q_THERMAL : TCF_Q_SHUTTER;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            thermal_condition_flag <= 1'b0;
            shutter_celsius <= '0;
        end else if (resp_valid) begin
            // a stray answer lands in the register of the last query kind
            if (q_kind_r == TCF_Q_THERMAL) begin
                thermal_condition_flag <= resp_value[0];
            end else begin
                shutter_celsius <= resp_value;
            end
        end
    end

endmodule // tcf_feature_ctrl

`default_nettype wire

// [design/tcf_regs.svh]
`ifndef TCF_REGS_SVH
`define TCF_REGS_SVH

// register byte offsets
`define TCF_OFS_MODEL_ID 8'h00
`define TCF_OFS_USER_LABEL 8'h04
`define TCF_OFS_SCAN_KIND 8'h08
`define TCF_OFS_SENSOR_DIMS 8'h0C
`define TCF_OFS_OUT_LIMIT 8'h10
`define TCF_OFS_OUT_DIMS 8'h14
`define TCF_OFS_ROI_SHIFT 8'h18
`define TCF_OFS_SKIP_UNUSED 8'h1C
`define TCF_OFS_SAMPLE_LAYOUT 8'h20
`define TCF_OFS_PATTERN 8'h24
`define TCF_OFS_CAPTURE_MODE 8'h28
`define TCF_OFS_CAPTURE_CTRL 8'h2C
`define TCF_OFS_CALIB_CTRL 8'h30
`define TCF_OFS_REFRESH 8'h34
`define TCF_OFS_THERMAL 8'h38
`define TCF_OFS_SHUTTER_C 8'h3C
`define TCF_OFS_FEAT_BASE 8'h40
`define TCF_OFS_FEAT_LAST 8'h74

// feature slot indices (base + 4 * index)
`define TCF_FEAT_COUNT 14
`define TCF_FI_CALIB_PERIOD 1
`define TCF_FI_BACKDROP_MODE 10

// internal command letters, one per feature slot, in slot order
`define TCF_LETTERS {8'h6A, 8'h6B, 8'h53, 8'h49, 8'h45, 8'h4E, 8'h4A, \
                     8'h4B, 8'h41, 8'h42, 8'h55, 8'h4D, 8'h47, 8'h44}
`define TCF_CMD_CALIB 8'h6B
`define TCF_CMD_TEMP 8'h54
`define TCF_ARG_CALIB_ONCE 16'h0000
`define TCF_ARG_QUERY_THERMAL 16'h0001
`define TCF_ARG_QUERY_SHUTTER 16'h0002

// field positions and fixed values
`define TCF_BIT_BEGIN 0
`define TCF_BIT_END 1
`define TCF_BIT_BUSY_MSB 31
`define TCF_SKIP_FIXED 32'h0000_0001
`define TCF_MODE_SINGLE 2'h1
`define TCF_FRAMES_PER_UNIT_LOG2 8
`define TCF_USER_LABEL_RST 32'h0000_0000
`define TCF_FEAT_RST 16'h0000

`endif

// [design/tcf_pkg.sv]
package tcf_pkg;

    typedef enum logic [1:0] {
        TCF_RF_IDLE = 2'b01,
        TCF_RF_WAIT = 2'b10
    } tcf_refresh_state_t;

    typedef enum logic [1:0] {
        TCF_Q_THERMAL = 2'b01,
        TCF_Q_SHUTTER = 2'b10
    } tcf_query_kind_t;

endpackage

// [sim/tcf_feature_ctrl_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module tcf_feature_ctrl_sva #(
    parameter logic [31:0] MODEL_ID = 32'h0000_0001,
    parameter int FW = 16
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [7:0] cmd_letter,
    input wire logic [FW-1:0] cmd_arg,
    input wire logic integ_busy,
    input wire logic capture_active,
    input wire logic feature_refresh_request
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire wr = psel & penable & pready & pwrite;
    wire rd = psel & penable & pready & !pwrite;
    a_model_id: assert property (rd && paddr == 8'h00 |-> prdata == MODEL_ID)
        else $error("model id read wrong");
    a_skip_fixed: assert property (rd && paddr == 8'h1C |-> prdata == 32'h1)
        else $error("skip setting read wrong");
    a_busy_msb: assert property (rd && paddr == 8'h68 |-> prdata[31] == $past(integ_busy))
        else $error("backdrop busy bit wrong");
    a_calib_cmd: assert property (wr && paddr == 8'h30 && pwdata[0] |=>
        ##[0:300] (cmd_valid && cmd_letter == 8'h6B && cmd_arg == '0)) else $error("no calib");
    a_query_flag: assert property (wr && paddr == 8'h38 && pwdata[0] |=>
        ##[0:300] (cmd_valid && cmd_letter == 8'h54 && cmd_arg == 1)) else $error("no query 1");
    a_query_shut: assert property (wr && paddr == 8'h38 && pwdata[1:0] == 2'b10 |=>
        ##[0:300] (cmd_valid && cmd_letter == 8'h54 && cmd_arg == 2)) else $error("no query 2");
    a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid &&
        $stable(cmd_letter) && $stable(cmd_arg)) else $error("command dropped");
    a_cap_begin: assert property (wr && paddr == 8'h2C && pwdata[0] |=>
        ##[0:2] capture_active) else $error("capture not started");
    a_cap_end: assert property (wr && paddr == 8'h2C && pwdata[1:0] == 2'b10 |=>
        ##[0:2] !capture_active) else $error("capture not stopped");
    a_refresh_run: assert property (wr && paddr == 8'h34 && pwdata[0] |=>
        ##[0:2] feature_refresh_request) else $error("refresh not started");
endmodule // tcf_feature_ctrl_sva
bind tcf_feature_ctrl tcf_feature_ctrl_sva #(.MODEL_ID(MODEL_ID), .FW(FW)) u_sva (.*);
`default_nettype wire

// [sim/tcf_interp_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tcf_interp_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_letter,
    input wire logic [15:0] cmd_arg,
    input wire logic feature_refresh_request,
    output logic cmd_ready,
    output logic resp_valid,
    output logic [15:0] resp_value,
    output logic calib_done,
    output logic sync_valid,
    output logic [7:0] sync_letter,
    output logic [15:0] sync_value,
    output logic sync_done,
    output logic [15:0] cmd_count,
    output logic [7:0] last_letter,
    output logic [15:0] last_arg
);
    logic [4:0] wait_r;
    logic [4:0] cal_r;
    logic [1:0] sync_r;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wait_r <= 5'h00;
            cmd_ready <= 1'b0;
        end else begin
            wait_r <= cmd_valid ? wait_r + 5'h01 : 5'h00;
            cmd_ready <= cmd_valid && !cmd_ready && wait_r >= (slow ? 5'h10 : 5'h00);
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_count <= 16'h0000;
            last_letter <= 8'h00;
            last_arg <= 16'h0000;
            resp_valid <= 1'b0;
            resp_value <= 16'h0000;
            cal_r <= 5'h00;
            calib_done <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            resp_value <= ~resp_value;
            calib_done <= cal_r == 5'h01;
            if (cal_r != 5'h00)
                cal_r <= cal_r - 5'h01;
            if (cmd_valid && cmd_ready) begin
                cmd_count <= cmd_count + 16'h0001;
                last_letter <= cmd_letter;
                last_arg <= cmd_arg;
                if (cmd_letter == 8'h54) begin
                    resp_valid <= 1'b1;
                    resp_value <= cmd_arg == 16'h0001 ? 16'h0001 : 16'h0019;
                end
                if (cmd_letter == 8'h6B && cmd_arg == 16'h0000)
                    cal_r <= 5'h1F;
            end
        end
    end
    // refresh: one report for the correction set slot, then done
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync_r <= 2'h0;
            sync_valid <= 1'b0;
            sync_done <= 1'b0;
            sync_letter <= 8'h00;
            sync_value <= 16'h0000;
        end else begin
            sync_valid <= sync_r == 2'h1;
            sync_done <= sync_r == 2'h2;
            sync_letter <= sync_r == 2'h1 ? 8'h53 : ~sync_letter;
            sync_value <= sync_r == 2'h1 ? 16'h0007 : ~sync_value;
            if (sync_r == 2'h3)
                sync_r <= feature_refresh_request ? 2'h3 : 2'h0;
            else if (sync_r != 2'h0 || feature_refresh_request)
                sync_r <= sync_r + 2'h1;
        end
    end
endmodule // tcf_interp_model
`default_nettype wire

// [sim/tcf_feature_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tcf_feature_ctrl_tb;
    localparam logic [31:0] MID = 32'h0000_0A5C; // arbitrary value
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr, cmd_valid, cmd_ready, e;
    logic resp_valid, sync_valid, sync_done, feature_refresh_request, calib_done, calib_busy;
    logic frame_tick, integ_busy, pattern_source_select, capture_active, thermal_condition_flag;
    logic slow;
    logic [7:0] paddr, cmd_letter, sync_letter, last_letter;
    logic [15:0] cmd_arg, resp_value, sync_value, out_columns, out_rows, roi_column_shift;
    logic [15:0] roi_row_shift, shutter_celsius, cmd_count, last_arg, c0;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] capture_count_mode;
    int mismatches, n_checks;
    string lt = "jkSIENJKABUMGD";
    tcf_feature_ctrl #(.MODEL_ID(MID), .SCAN_KIND(32'h1), .SENSOR_COLS(16'h00A0),
        .SENSOR_ROWS(16'h0078), .LIMIT_COLS(16'h0050), .LIMIT_ROWS(16'h003C)) uut (.*);
    tcf_interp_model u_far (.*);
    always #4 clock = ~clock;
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bound(input int n);
        if (n >= 500) begin
            mismatches++;
            $display("Error %0t: timeout", $time);
            finish_test;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 500);
        bound(n);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wait_cmd;
        int n;
        n = 0;
        while (cmd_count === c0 && n < 500) begin
            @(posedge clock);
            n++;
        end
        bound(n);
    endtask
    task automatic wr_cmd(input logic [7:0] a, input logic [31:0] d);
        c0 = cmd_count;
        apb(1'b1, a, d);
        wait_cmd;
    endtask
    task automatic wait_low(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b0 && n < 500) begin
            @(posedge clock);
            n++;
        end
        bound(n);
    endtask
    task automatic tick;
        frame_tick <= 1'b1;
        @(posedge clock);
        frame_tick <= 1'b0;
        @(posedge clock);
    endtask
    task automatic t_ident;
        apb(1, 8'h00, 32'hFFFF_FFFF);
        apb(0, 8'h00, 0);
        chk(q, MID);
        apb(0, 8'h08, 0);
        chk(q, 32'h1);
        apb(0, 8'h0C, 0);
        chk(q, 32'h0078_00A0);
        apb(0, 8'h10, 0);
        chk(q, 32'h003C_0050);
        apb(0, 8'h14, 0);
        chk(q, 32'h0030_0040);
        apb(0, 8'h80, 0);
        chk(e, 1);
        apb(1, 8'h04, 32'hA5C3_0F96);
        apb(0, 8'h04, 0);
        chk(q, 32'hA5C3_0F96);
        apb(1, 8'h1C, 0);
        apb(0, 8'h1C, 0);
        chk(q, 32'h1);
        $display("ident done");
    endtask
    task automatic t_ctrl;
        apb(1, 8'h18, 32'h000C_0010);
        apb(1, 8'h24, 1);
        apb(1, 8'h28, 1);
        chk({roi_row_shift, roi_column_shift}, 32'h000C_0010);
        chk(pattern_source_select, 1);
        chk(capture_count_mode, 1);
        apb(1, 8'h24, 0);
        chk(pattern_source_select, 0);
        apb(1, 8'h2C, 1);
        chk(capture_active, 1);
        apb(1, 8'h2C, 2);
        chk(capture_active, 0);
        apb(1, 8'h2C, 1);
        tick;
        chk(capture_active, 0);
        $display("control done");
    endtask
    task automatic t_features;
        integ_busy <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            slow <= i[0];
            wr_cmd(8'(8'h40 + 4 * i), 32'h0300 + i);
            chk({last_letter, last_arg}, {lt[i], 16'h0300 + 16'(i)});
            apb(0, 8'(8'h40 + 4 * i), 0);
            chk(q, {i == 10, 15'h0, 16'h0300 + 16'(i)});
        end
        slow <= 1'b1;
        c0 = cmd_count;
        apb(1, 8'h48, 5);
        apb(1, 8'h48, 6);
        c0 = c0 + 16'h0001;
        wait_cmd;
        chk({last_letter, last_arg}, 24'h53_0006);
        slow <= 1'b0;
        integ_busy <= 1'b0;
        $display("features done");
    endtask
    task automatic t_calib;
        wr_cmd(8'h30, 1);
        chk({last_letter, last_arg}, 24'h6B_0000);
        chk(calib_busy, 1);
        wait_low(calib_busy);
        wr_cmd(8'h44, 1);
        c0 = cmd_count;
        repeat (255) tick;
        repeat (4) @(posedge clock);
        chk(cmd_count, c0);
        tick;
        wait_cmd;
        chk({last_letter, last_arg}, 24'h6B_0000);
        wr_cmd(8'h44, 0);
        $display("calibration done");
    endtask
    task automatic t_query;
        wr_cmd(8'h38, 1);
        chk({last_letter, last_arg}, 24'h54_0001);
        repeat (3) @(posedge clock);
        chk(thermal_condition_flag, 1);
        wr_cmd(8'h38, 2);
        chk({last_letter, last_arg}, 24'h54_0002);
        repeat (3) @(posedge clock);
        apb(0, 8'h3C, 0);
        chk(q, 32'h19);
        chk(shutter_celsius, 16'h0019);
        apb(1, 8'h34, 1);
        wait_low(feature_refresh_request);
        apb(0, 8'h48, 0);
        chk(q, 32'h7);
        $display("query done");
    endtask
    initial begin
        {clock, rst_b, psel, penable, pwrite, slow, frame_tick, integ_busy} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        out_columns = 16'h0040;
        out_rows = 16'h0030;
        mismatches = 0;
        n_checks = 0;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_ident;
        t_ctrl;
        t_features;
        t_calib;
        t_query;
        finish_test;
    end
endmodule // tcf_feature_ctrl_tb
`default_nettype wire
